/* bmsd_chk_checker.sv */
`timescale 1ns/1ps
// Decode and test port relations seen at the ports
module bmsd_chk (
   input wire clk, rst_b, test_prog_active, test_area_wr, test_port_disable,
   input wire [16:0] host_addr,
   input wire [1:0] test_area,
   input wire [7:0] page_rdata_q,
   input wire boot_area_select_lo_q, boot_area_select_hi_q, main_sector_zero_select_q,
   input wire test_port_enabled_q, bus_connected_q,
   input wire [3:0] test_area_wr_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_lo; boot_area_select_lo_q |-> $past(host_addr) <= 17'h01fff; endproperty
   a_lo: assert property (p_lo) else $error("low boot select range");
   property p_hi; boot_area_select_hi_q |-> $past(host_addr) inside {[17'h02000:17'h03fff]}; endproperty
   a_hi: assert property (p_hi) else $error("high boot select range");
   property p_ex; main_sector_zero_select_q |-> !boot_area_select_lo_q && !boot_area_select_hi_q
      && ($past(host_addr) <= 17'h03fff || $past(host_addr) >= 17'h10000); endproperty
   a_ex: assert property (p_ex) else $error("sector zero select overlap");
   property p_rs; $past(!rst_b) |-> test_port_enabled_q && page_rdata_q == 8'h00; endproperty
   a_rs: assert property (p_rs) else $error("reset values");
   property p_pa; test_prog_active && test_port_enabled_q
      |=> !bus_connected_q && !main_sector_zero_select_q; endproperty
   a_pa: assert property (p_pa) else $error("bus not released");
   property p_tw; test_area_wr && test_prog_active && test_port_enabled_q && !test_port_disable
      |=> test_area_wr_q == 4'h1 << $past(test_area); endproperty
   a_tw: assert property (p_tw) else $error("test write strobe");
   // Main scenarios reached
   cover property (boot_area_select_lo_q);
   cover property (main_sector_zero_select_q && $past(host_addr) < 17'h04000);
   cover property (test_area_wr_q[3]);
endmodule
bind bmsd_swap_decoder bmsd_chk u_chk (.*);

/* bmsd_defs.vh */
`ifndef BMSD_DEFS_VH
`define BMSD_DEFS_VH
// Host address width (segments 0 and 1)
`define BMSD_ADDR_W 17
// Memory page control register
`define BMSD_PAGE_RESET 8'h00
`define BMSD_EXE_SRC_BIT 6
// Decode ranges
`define BMSD_BOOT_LO_FIRST 17'h00000
`define BMSD_BOOT_LO_LAST 17'h01fff
`define BMSD_BOOT_HI_FIRST 17'h02000
`define BMSD_BOOT_HI_LAST 17'h03fff
`define BMSD_MAIN_FIRST 17'h10000
`define BMSD_MAIN_LAST 17'h1ffff
`define BMSD_EXEC_FIRST 17'h00000
`define BMSD_EXEC_LAST 17'h03fff
// Page register width
`define BMSD_PAGE_W 8
// Test port and bus connection state out of reset
`define BMSD_TEST_PORT_RESET 1'b1
`define BMSD_BUS_CONN_RESET 1'b1
// Memory areas reachable through the test port
`define BMSD_AREA_COUNT 4
`endif

/* bmsd_host.sv */
`timescale 1ns/1ps
// Host side of the multiplexed bus, one access per call
module bmsd_host (
   input wire clk,
   output logic [16:0] host_addr,
   output logic host_addr_valid, page_wr, page_rd,
   output logic [7:0] page_wdata
);
   initial {host_addr, host_addr_valid, page_wr, page_rd, page_wdata} = '0;
   // Fetch or page access held for one cycle, bus inverted once released
   task acc(input logic w, r, input logic [7:0] d, input logic [16:0] a);
      @(negedge clk) {page_wr, page_rd, page_wdata, host_addr, host_addr_valid} = {w, r, d, a, !r};
      @(negedge clk) {page_wr, page_rd, host_addr_valid, host_addr, page_wdata} = {3'h0, ~a, ~d};
   endtask
endmodule

/* bmsd_swap_decoder.v */
`timescale 1ns/1ps
`include "bmsd_defs.vh"
module bmsd_swap_decoder (
   input wire clk,
   input wire rst_b,
   input wire [`BMSD_ADDR_W-1:0] host_addr,
   input wire host_addr_valid,
   input wire page_wr,
   input wire page_rd,
   input wire [7:0] page_wdata,
   input wire test_port_disable,
   input wire test_prog_active,
   input wire [1:0] test_area,
   input wire test_area_wr,
   output reg [7:0] page_rdata_q,
   output reg boot_area_select_lo_q,
   output reg boot_area_select_hi_q,
   output reg main_sector_zero_select_q,
   output reg test_port_enabled_q,
   output reg bus_connected_q,
   output reg [3:0] test_area_wr_q
);

   // Map modes of the swap bit
   localparam [0:0] MAP_BOOT = 1'b0;
   localparam [0:0] MAP_MAIN = 1'b1;

   // Page register and its next value
   reg [7:0] memory_page_control_q;
   wire [7:0] page_d;
   // Host access qualifiers
   reg host_on_bus;
   reg page_wr_ok;
   reg page_rd_ok;
   reg fetch_ok;
   // Swap input and current map mode
   reg exe_src;
   reg map_mode;
   // Range bound terms
   reg boot_lo_above;
   reg boot_lo_below;
   reg boot_hi_above;
   reg boot_hi_below;
   reg main_above;
   reg main_below;
   reg exec_above;
   reg exec_below;
   // Range hits
   reg in_boot_lo;
   reg in_boot_hi;
   reg in_main;
   reg in_exec;
   // Select next values
   reg sel_lo_d;
   reg sel_hi_d;
   reg sel_main_d;
   // Read back next value
   reg [7:0] page_rdata_d;
   // Test port next values
   reg test_port_enabled_d;
   reg bus_connected_d;
   // Test port write decode
   reg prog_ok;
   reg [3:0] area_onehot;
   // Area strobe next values
   wire [3:0] test_area_wr_d;
   // Generate indices
   genvar gb;
   genvar gi;

   // Device sits on the host bus only outside test programming
   always @* begin
      host_on_bus = bus_connected_q && !test_prog_active;
   end

   // Page accesses refused while off the bus
   always @* begin
      page_wr_ok = host_on_bus && page_wr;
      page_rd_ok = host_on_bus && page_rd;
   end

   // Fetch cycles decoded only while on the bus
   always @* begin
      fetch_ok = host_on_bus && host_addr_valid;
   end

   // Page register next value, one bit at a time
   generate
      for (gb = 0; gb < `BMSD_PAGE_W; gb = gb + 1) begin : g_page_bit
         assign page_d[gb] = page_wr_ok ?
            page_wdata[gb] :
            memory_page_control_q[gb];
      end
   endgenerate

   // Page register, cleared so the first fetches hit the boot area
   always @(posedge clk) begin
      if (!rst_b) begin
         memory_page_control_q <= `BMSD_PAGE_RESET;
      end else begin
         memory_page_control_q <= page_d;
      end
   end

   // Swap bit from the next value so a write steers its own fetch
   always @* begin
      exe_src = page_d[`BMSD_EXE_SRC_BIT];
   end

   // Map mode follows the swap bit
   always @* begin
      if (exe_src) begin
         map_mode = MAP_MAIN;
      end else begin
         map_mode = MAP_BOOT;
      end
   end

   // Low boot area bounds
   always @* begin
      boot_lo_above = (host_addr >= `BMSD_BOOT_LO_FIRST);
      boot_lo_below = (host_addr <= `BMSD_BOOT_LO_LAST);
      in_boot_lo = boot_lo_above && boot_lo_below;
   end

   // High boot area bounds
   always @* begin
      boot_hi_above = (host_addr >= `BMSD_BOOT_HI_FIRST);
      boot_hi_below = (host_addr <= `BMSD_BOOT_HI_LAST);
      in_boot_hi = boot_hi_above && boot_hi_below;
   end

   // Sector zero home range bounds
   always @* begin
      main_above = (host_addr >= `BMSD_MAIN_FIRST);
      main_below = (host_addr <= `BMSD_MAIN_LAST);
      in_main = main_above && main_below;
   end

   // Execution range bounds
   always @* begin
      exec_above = (host_addr >= `BMSD_EXEC_FIRST);
      exec_below = (host_addr <= `BMSD_EXEC_LAST);
      in_exec = exec_above && exec_below;
   end

   // Boot area selects live only in the boot map
   always @* begin
      sel_lo_d = 1'b0;
      sel_hi_d = 1'b0;
      case (map_mode)
         MAP_BOOT: begin
            sel_lo_d = fetch_ok && in_boot_lo;
            sel_hi_d = fetch_ok && in_boot_hi;
         end
         MAP_MAIN: begin
            sel_lo_d = 1'b0;
            sel_hi_d = 1'b0;
         end
         default: begin
            sel_lo_d = 1'b0;
            sel_hi_d = 1'b0;
         end
      endcase
   end

   // Sector zero moves to the execution range; its select never overlaps the boot selects
   always @* begin
      sel_main_d = 1'b0;
      case (map_mode)
         MAP_BOOT: begin
            sel_main_d = fetch_ok && in_main;
         end
         MAP_MAIN: begin
            sel_main_d = fetch_ok && in_exec;
         end
         default: begin
            sel_main_d = 1'b0;
         end
      endcase
   end

   // Low boot select flop
   always @(posedge clk) begin
      if (!rst_b) begin
         boot_area_select_lo_q <= 1'b0;
      end else begin
         boot_area_select_lo_q <= sel_lo_d;
      end
   end

   // High boot select flop
   always @(posedge clk) begin
      if (!rst_b) begin
         boot_area_select_hi_q <= 1'b0;
      end else begin
         boot_area_select_hi_q <= sel_hi_d;
      end
   end

   // Sector zero select flop
   always @(posedge clk) begin
      if (!rst_b) begin
         main_sector_zero_select_q <= 1'b0;
      end else begin
         main_sector_zero_select_q <= sel_main_d;
      end
   end

   // Read data holds until the next accepted read
   always @* begin
      if (page_rd_ok) begin
         page_rdata_d = memory_page_control_q;
      end else begin
         page_rdata_d = page_rdata_q;
      end
   end

   // Read data flop
   always @(posedge clk) begin
      if (!rst_b) begin
         page_rdata_q <= `BMSD_PAGE_RESET;
      end else begin
         page_rdata_q <= page_rdata_d;
      end
   end

   // Test port stays on until a disable pulse
   always @* begin
      if (test_port_disable) begin
         test_port_enabled_d = 1'b0;
      end else begin
         test_port_enabled_d = test_port_enabled_q;
      end
   end

   // Test port flop, on out of reset
   always @(posedge clk) begin
      if (!rst_b) begin
         test_port_enabled_q <= `BMSD_TEST_PORT_RESET;
      end else begin
         test_port_enabled_q <= test_port_enabled_d;
      end
   end

   // Device leaves the host bus while programming runs with the test port on
   always @* begin
      bus_connected_d = 1'b1;
      if (test_prog_active && test_port_enabled_q) begin
         bus_connected_d = 1'b0;
      end
   end

   // Bus connection flop
   always @(posedge clk) begin
      if (!rst_b) begin
         bus_connected_q <= `BMSD_BUS_CONN_RESET;
      end else begin
         bus_connected_q <= bus_connected_d;
      end
   end

   // Test port writes need the port on and programming running
   always @* begin
      prog_ok = test_port_enabled_q && test_prog_active;
   end

   // One-hot form of the requested area
   always @* begin
      area_onehot = 4'h1 << test_area;
   end

   // Per area write strobes: logic, config, main flash, secondary flash
   generate
      for (gi = 0; gi < `BMSD_AREA_COUNT; gi = gi + 1) begin : g_area
         assign test_area_wr_d[gi] = prog_ok && test_area_wr && area_onehot[gi];
         always @(posedge clk) begin
            if (!rst_b) begin
               test_area_wr_q[gi] <= 1'b0;
            end else begin
               test_area_wr_q[gi] <= test_area_wr_d[gi];
            end
         end
      end
   endgenerate

endmodule

/* boot_memory_swap_decoder_bench.sv */
`timescale 1ns/1ps
module boot_memory_swap_decoder_bench;
   logic clk = 0, rst_b = 0, test_port_disable = 0, test_prog_active = 0, test_area_wr = 0;
   logic [1:0] test_area = 0;
   logic [16:0] host_addr;
   logic host_addr_valid, page_wr, page_rd;
   logic [7:0] page_wdata;
   wire [7:0] page_rdata_q;
   wire boot_area_select_lo_q, boot_area_select_hi_q, main_sector_zero_select_q, test_port_enabled_q, bus_connected_q;
   wire [3:0] test_area_wr_q;
   int err_count = 0, samples_checked = 0, cyc = 0, i, b;
   logic [16:0] tbl [8] = '{17'h0, 17'h1fff, 17'h2000, 17'h3fff, 17'h4000, 17'hffff, 17'h10000, 17'h1ffff};
   always #5 clk = ~clk;
   bmsd_swap_decoder uut (.*);
   bmsd_host host (.*);
   // Hang guard
   always @(posedge clk) if (++cyc > 2000) begin
      err_count++;
      wrap_up();
   end
   task chk(input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task wrap_up;
      if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Expected lo, hi, sector zero selects
   function logic [7:0] sel(input logic s, input logic [16:0] a);
      return {5'h0, !s && a <= 17'h1fff, !s && a >= 17'h2000 && a <= 17'h3fff, s ? a <= 17'h3fff : a >= 17'h10000};
   endfunction
   task tw(input logic [1:0] a, input logic [3:0] e);
      @(negedge clk) {test_area, test_area_wr} = {a, 1'b1};
      @(negedge clk) test_area_wr = 0;
      chk(test_area_wr_q, e);
   endtask
   // Reset, map both ways, then test port
   initial begin
      repeat (12) @(negedge clk);
      rst_b = 1;
      chk({test_port_enabled_q, bus_connected_q}, 8'h03);
      host.acc(0, 1, 0, 0);
      chk(page_rdata_q, 8'h00);
      for (b = 0; b < 2; b++) begin
         for (i = 0; i < 8; i++) begin
            host.acc(i == 0, 0, b ? 8'h40 : 8'hbf, tbl[i]);
            chk({boot_area_select_lo_q, boot_area_select_hi_q, main_sector_zero_select_q}, sel(b, tbl[i]));
         end
         host.acc(0, 1, 0, 0);
         chk(page_rdata_q, b ? 8'h40 : 8'hbf);
      end
      test_prog_active = 1;
      host.acc(0, 0, 0, 0);
      chk({bus_connected_q, main_sector_zero_select_q}, 8'h00);
      for (i = 0; i < 4; i++) tw(i[1:0], 4'h1 << i);
      @(negedge clk) test_port_disable = 1;
      @(negedge clk) test_port_disable = 0;
      chk({test_port_enabled_q, bus_connected_q}, 8'h00);
      tw(0, 0);
      wrap_up();
   end
endmodule
